//--- rtl/sse_exec.sv
// Notes on behaviour
// - square roots decode from register opcodes 688 (real) and 698 (long).
// - denormal operand with normalizing mode set gives reserved-encoding fault.
// - each root exception faults only when its mask bit is clear.
// - root result too large flags overflow.
// - root result too small flags underflow.
// - operand below -0 flags invalid operation.
// - signalling nan operand flags invalid operation.
// - root that needs rounding flags inexact.
// - stores copy one register or successive registers from the lowest upward.
// - store address is the first byte written, any addressing mode upstream.
// - byte stores write one low byte, short stores two low bytes.
// - word, long, triple, quad write 4, 8, 12, 16 bytes ascending.
// - only integer byte and short stores may raise integer overflow.
`default_nettype none
module sse_exec
  import sse_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_ISSUE,
  input wire logic I_FMT_MEM,
  input wire logic [11:0] I_OPCODE,
  input wire logic [127:0] I_SRC_DATA,
  input wire logic [31:0] I_DST_ADDR,
  input wire logic I_AC_NORM,
  input wire logic [3:0] I_AC_MASK,
  input wire logic [63:0] I_FP_SRC,
  input wire logic I_SQ_OVF,
  input wire logic I_SQ_UNF,
  input wire logic I_SQ_INX,
  input wire logic I_MEM_READY,
  output logic O_BUSY,
  output logic O_MEM_VALID,
  output logic [31:0] O_MEM_ADDR,
  output logic [31:0] O_MEM_DATA,
  output logic [2:0] O_MEM_NBYTES,
  output logic O_DONE,
  output logic O_FAULT,
  output logic [1:0] O_FAULT_KIND,
  output logic [3:0] O_FP_EXC
);
  function automatic logic in_range(input logic [31:0] w, input logic signed [31:0] lo,
                                    input logic signed [31:0] hi);
    return ($signed(w) >= lo) && ($signed(w) <= hi);
  endfunction

  sse_sqrt_if sq ();
  sse_sqrt_chk u_chk (.sq(sq));

  sse_state_t state_ff, nxt_state;
  logic valid_ff, nxt_valid;
  logic [31:0] addr_ff, nxt_addr;
  logic [31:0] data_ff, nxt_data;
  logic [95:0] rest_ff, nxt_rest;
  logic [1:0] left_ff, nxt_left;
  logic [2:0] nbytes_ff, nxt_nbytes;
  logic done_ff, nxt_done;
  logic fault_ff, nxt_fault;
  sse_fault_t kind_ff, nxt_kind;
  logic [3:0] exc_ff, nxt_exc;

  logic [7:0] mem_opc;
  logic take;
  logic is_sqrt;
  logic is_store;
  logic int_ovf;
  logic [1:0] save_left;
  logic [2:0] save_nbytes;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  assign mem_opc = I_OPCODE[MEM_OPC_W-1:0];
  assign take = I_ISSUE && (state_ff == SEQ_IDLE);
  assign is_sqrt = !I_FMT_MEM && (I_OPCODE == OPC_SQRT_REAL
                                  || I_OPCODE == OPC_SQRT_LONG);

  assign sq.is_long = (I_OPCODE == OPC_SQRT_LONG);
  assign sq.opnd = I_FP_SRC;
  assign sq.norm_mode = I_AC_NORM;
  assign sq.mask = I_AC_MASK;
  assign sq.res_ovf = I_SQ_OVF;
  assign sq.res_unf = I_SQ_UNF;
  assign sq.res_inx = I_SQ_INX;

  always_comb begin
    is_store = I_FMT_MEM;
    int_ovf = 1'h0;
    save_left = LEFT_NONE;
    save_nbytes = BYTES_WORD;
    unique case (mem_opc)
      OPC_SAVE_WORD: save_nbytes = BYTES_WORD;
      OPC_SAVE_ORD_BYTE: save_nbytes = BYTES_BYTE;
      OPC_SAVE_ORD_SHORT: save_nbytes = BYTES_SHORT;
      OPC_SAVE_INT_BYTE: begin
        save_nbytes = BYTES_BYTE;
        int_ovf = !in_range(I_SRC_DATA[WORD_W-1:0], INT8_MIN, INT8_MAX);
      end
      OPC_SAVE_INT_SHORT: begin
        save_nbytes = BYTES_SHORT;
        int_ovf = !in_range(I_SRC_DATA[WORD_W-1:0], INT16_MIN, INT16_MAX);
      end
      OPC_SAVE_LONG: save_left = LEFT_LONG;
      OPC_SAVE_TRIPLE: save_left = LEFT_TRIPLE;
      OPC_SAVE_QUAD: save_left = LEFT_QUAD;
      default: is_store = 1'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_valid = valid_ff;
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_rest = rest_ff;
    nxt_left = left_ff;
    nxt_nbytes = nbytes_ff;
    nxt_done = 1'h0;
    nxt_fault = 1'h0;
    nxt_kind = FLT_NONE;
    nxt_exc = '0;
    unique case (state_ff)
      SEQ_IDLE: begin
        if (take && is_sqrt) begin
          nxt_done = 1'h1;
          nxt_exc = sq.exc;
          nxt_fault = sq.fault;
          nxt_kind = sq.resv ? FLT_RESV_ENC : (sq.fault ? FLT_FP_EXC : FLT_NONE);
        end else if (take && is_store && int_ovf) begin
          // faulting store writes nothing
          nxt_done = 1'h1;
          nxt_fault = 1'h1;
          nxt_kind = FLT_INT_OVF;
        end else if (take && is_store) begin
          nxt_state = SEQ_SAVE;
          nxt_valid = 1'h1;
          nxt_addr = I_DST_ADDR;
          nxt_data = I_SRC_DATA[WORD_W-1:0];
          nxt_rest = I_SRC_DATA[127:WORD_W];
          nxt_left = save_left;
          nxt_nbytes = save_nbytes;
        end
      end
      SEQ_SAVE: begin
        if (I_MEM_READY) begin
          if (left_ff == LEFT_NONE) begin
            nxt_state = SEQ_IDLE;
            nxt_valid = 1'h0;
            nxt_done = 1'h1;
          end else begin
            // next register, next word up
            nxt_addr = addr_ff + ADDR_STEP;
            nxt_data = rest_ff[WORD_W-1:0];
            nxt_rest = {{WORD_W{1'h0}}, rest_ff[95:WORD_W]};
            nxt_left = left_ff - LEFT_ONE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_ff <= SEQ_IDLE;
      valid_ff <= 1'h0;
      addr_ff <= '0;
      data_ff <= '0;
      rest_ff <= '0;
      left_ff <= LEFT_NONE;
      nbytes_ff <= BYTES_WORD;
      done_ff <= 1'h0;
      fault_ff <= 1'h0;
      kind_ff <= FLT_NONE;
      exc_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      valid_ff <= nxt_valid;
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      rest_ff <= nxt_rest;
      left_ff <= nxt_left;
      nbytes_ff <= nxt_nbytes;
      done_ff <= nxt_done;
      fault_ff <= nxt_fault;
      kind_ff <= nxt_kind;
      exc_ff <= nxt_exc;
    end
  end

  assign O_BUSY = valid_ff;
  assign O_MEM_VALID = valid_ff;
  assign O_MEM_ADDR = addr_ff;
  assign O_MEM_DATA = data_ff;
  assign O_MEM_NBYTES = nbytes_ff;
  assign O_DONE = done_ff;
  assign O_FAULT = fault_ff;
  assign O_FAULT_KIND = kind_ff;
  assign O_FP_EXC = exc_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic real_take;
  assign real_take = take && !I_FMT_MEM && (I_OPCODE == OPC_SQRT_REAL);

  a_sqrt_decode: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    take && is_sqrt |=> O_DONE && !O_MEM_VALID)
    else $error("root not completed");
  a_resv_enc_fault: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    real_take && I_AC_NORM && ~|I_FP_SRC[REAL_EXP_HI:REAL_EXP_LO]
    && |I_FP_SRC[REAL_FRAC_HI:0] |=> O_FAULT && O_FAULT_KIND == FLT_RESV_ENC && O_FP_EXC == '0)
    else $error("missing reserved encoding fault");
  a_mask_gate: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    O_FP_EXC != '0 |-> O_FAULT == |(O_FP_EXC & ~$past(I_AC_MASK)))
    else $error("mask not honoured");
  a_ovf_unf_flag: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    take && is_sqrt && !I_AC_NORM
    |=> O_FP_EXC[EXC_OVF] == $past(I_SQ_OVF) && O_FP_EXC[EXC_UNF] == $past(I_SQ_UNF))
    else $error("range flag wrong");
  a_neg_invalid: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    real_take && !I_AC_NORM && I_FP_SRC[REAL_SIGN] && |I_FP_SRC[REAL_SIGN-1:0]
    && !(&I_FP_SRC[REAL_EXP_HI:REAL_EXP_LO]) |=> O_FP_EXC[EXC_INV])
    else $error("negative operand not invalid");
  a_snan_invalid: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    real_take && !I_AC_NORM && &I_FP_SRC[REAL_EXP_HI:REAL_EXP_LO]
    && !I_FP_SRC[REAL_FRAC_HI] && |I_FP_SRC[REAL_FRAC_HI:0] |=> O_FP_EXC[EXC_INV])
    else $error("signalling nan not invalid");
  a_inexact_flag: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    take && is_sqrt && !I_AC_NORM |=> O_FP_EXC[EXC_INX] == $past(I_SQ_INX))
    else $error("inexact flag wrong");
  a_first_word: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    take && is_store && !int_ovf |=> O_MEM_VALID && O_MEM_ADDR == $past(I_DST_ADDR)
    && O_MEM_DATA == $past(I_SRC_DATA[WORD_W-1:0]))
    else $error("first store beat wrong");
  a_narrow_size: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    take && I_FMT_MEM && mem_opc == OPC_SAVE_ORD_SHORT |=> O_MEM_NBYTES == BYTES_SHORT)
    else $error("short store size wrong");
  a_quad_beats: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    take && I_FMT_MEM && mem_opc == OPC_SAVE_QUAD ##1 I_MEM_READY[*4]
    |=> O_DONE && O_MEM_ADDR == $past(I_DST_ADDR, 5) + ADDR_STEP * 3)
    else $error("quad store beats wrong");
  a_int_ovf_fault: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    O_FAULT_KIND == FLT_INT_OVF |-> $past(I_FMT_MEM) && ($past(mem_opc) == OPC_SAVE_INT_BYTE
    || $past(mem_opc) == OPC_SAVE_INT_SHORT) && !O_MEM_VALID)
    else $error("integer overflow from wrong store");
  a_int_byte_range: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    take && I_FMT_MEM && mem_opc == OPC_SAVE_INT_BYTE && I_SRC_DATA[WORD_W-1:0] == INT8_MAX
    |=> !O_FAULT && O_MEM_VALID)
    else $error("fitting byte refused");
endmodule // sse_exec
`default_nettype wire

//--- rtl/sse_pkg.sv
`default_nettype none
package sse_pkg;
  // register-format opcodes of the two roots
  localparam logic [11:0] OPC_SQRT_REAL = 12'h688;
  localparam logic [11:0] OPC_SQRT_LONG = 12'h698;
  // memory-format opcodes of the stores
  localparam logic [7:0] OPC_SAVE_WORD = 8'h92;
  localparam logic [7:0] OPC_SAVE_ORD_BYTE = 8'h82;
  localparam logic [7:0] OPC_SAVE_ORD_SHORT = 8'h8A;
  localparam logic [7:0] OPC_SAVE_INT_BYTE = 8'hC2;
  localparam logic [7:0] OPC_SAVE_INT_SHORT = 8'hCA;
  localparam logic [7:0] OPC_SAVE_LONG = 8'h9A;
  localparam logic [7:0] OPC_SAVE_TRIPLE = 8'hA2;
  localparam logic [7:0] OPC_SAVE_QUAD = 8'hB2;
  localparam int MEM_OPC_W = 8;
  // byte counts of one memory beat
  localparam logic [2:0] BYTES_BYTE = 3'h1;
  localparam logic [2:0] BYTES_SHORT = 3'h2;
  localparam logic [2:0] BYTES_WORD = 3'h4;
  // further beats after the first
  localparam logic [1:0] LEFT_NONE = 2'h0;
  localparam logic [1:0] LEFT_LONG = 2'h1;
  localparam logic [1:0] LEFT_TRIPLE = 2'h2;
  localparam logic [1:0] LEFT_QUAD = 2'h3;
  localparam logic [1:0] LEFT_ONE = 2'h1;
  localparam logic [31:0] ADDR_STEP = 32'h4;
  localparam int WORD_W = 32;
  // signed ranges of the narrow integer stores
  localparam logic signed [31:0] INT8_MIN = 32'hFFFFFF80;
  localparam logic signed [31:0] INT8_MAX = 32'h0000007F;
  localparam logic signed [31:0] INT16_MIN = 32'hFFFF8000;
  localparam logic signed [31:0] INT16_MAX = 32'h00007FFF;
  // real operand fields
  localparam int REAL_SIGN = 31;
  localparam int REAL_EXP_HI = 30;
  localparam int REAL_EXP_LO = 23;
  localparam int REAL_FRAC_HI = 22;
  // long real operand fields
  localparam int LONG_SIGN = 63;
  localparam int LONG_EXP_HI = 62;
  localparam int LONG_EXP_LO = 52;
  localparam int LONG_FRAC_HI = 51;
  // exception bits, same positions in the mask word
  localparam int EXC_OVF = 0;
  localparam int EXC_UNF = 1;
  localparam int EXC_INV = 2;
  localparam int EXC_INX = 3;
  localparam int EXC_W = 4;
  typedef enum logic [1:0] {
    FLT_NONE = 2'h0,
    FLT_INT_OVF = 2'h1,
    FLT_RESV_ENC = 2'h2,
    FLT_FP_EXC = 2'h3
  } sse_fault_t;
  typedef enum logic {
    SEQ_IDLE = 1'h0,
    SEQ_SAVE = 1'h1
  } sse_state_t;
endpackage
`default_nettype wire

//--- rtl/sse_sqrt_chk.sv
`default_nettype none
module sse_sqrt_chk
  import sse_pkg::*;
(
  sse_sqrt_if.chk sq
);
  logic sign;
  logic exp_zero;
  logic exp_ones;
  logic frac_zero;
  logic quiet;
  logic denorm;
  logic nan;

  always_comb begin
    if (sq.is_long) begin
      sign = sq.opnd[LONG_SIGN];
      exp_zero = ~|sq.opnd[LONG_EXP_HI:LONG_EXP_LO];
      exp_ones = &sq.opnd[LONG_EXP_HI:LONG_EXP_LO];
      frac_zero = ~|sq.opnd[LONG_FRAC_HI:0];
      quiet = sq.opnd[LONG_FRAC_HI];
    end else begin
      sign = sq.opnd[REAL_SIGN];
      exp_zero = ~|sq.opnd[REAL_EXP_HI:REAL_EXP_LO];
      exp_ones = &sq.opnd[REAL_EXP_HI:REAL_EXP_LO];
      frac_zero = ~|sq.opnd[REAL_FRAC_HI:0];
      quiet = sq.opnd[REAL_FRAC_HI];
    end
    denorm = exp_zero && !frac_zero;
    nan = exp_ones && !frac_zero;
    sq.resv = sq.norm_mode && denorm;
    sq.exc = '0;
    // reserved encoding preempts the arithmetic exceptions
    if (!sq.resv) begin
      sq.exc[EXC_OVF] = sq.res_ovf;
      sq.exc[EXC_UNF] = sq.res_unf;
      // -0 and negative nan are not below -0
      sq.exc[EXC_INV] = (sign && !(exp_zero && frac_zero) && !nan)
                        || (nan && !quiet);
      sq.exc[EXC_INX] = sq.res_inx;
    end
    sq.fault = sq.resv || |(sq.exc & ~sq.mask);
  end
endmodule // sse_sqrt_chk
`default_nettype wire

//--- rtl/sse_sqrt_if.sv
`default_nettype none
interface sse_sqrt_if;
  logic is_long;
  logic [63:0] opnd;
  logic norm_mode;
  logic [3:0] mask;
  logic res_ovf;
  logic res_unf;
  logic res_inx;
  logic [3:0] exc;
  logic resv;
  logic fault;
  modport chk (
    input is_long, opnd, norm_mode, mask, res_ovf, res_unf, res_inx,
    output exc, resv, fault
  );
  modport core (
    output is_long, opnd, norm_mode, mask, res_ovf, res_unf, res_inx,
    input exc, resv, fault
  );
endinterface
`default_nettype wire

//--- tb/sse_mem_model.sv
`default_nettype none
module sse_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic valid,
  input wire logic [31:0] addr,
  input wire logic [31:0] data,
  input wire logic [2:0] nbytes,
  output logic ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] cnt_ff;
  logic [31:0] got_addr[$];
  logic [31:0] got_data[$];
  logic [2:0] got_nb[$];
  //////////////////////////////////////////////////////////////////////////
  // slow mode grants one cycle in three, so a beat must hold through stalls
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 2'h0;
      ready <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff == 2'h2) ? 2'h0 : cnt_ff + 2'h1;
      ready <= slow ? (cnt_ff == 2'h1) : 1'b1;
      if (valid && ready) begin
        got_addr.push_back(addr);
        // only the low nbytes bytes reach memory
        got_data.push_back(nbytes == 3'h1 ? {24'h0, data[7:0]} :
                           nbytes == 3'h2 ? {16'h0, data[15:0]} : data);
        got_nb.push_back(nbytes);
      end
    end
  end
endmodule // sse_mem_model
`default_nettype wire

//--- tb/store_and_sqrt_exec_tb.sv
`default_nettype none
`define SSE_CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module store_and_sqrt_exec_tb
  import sse_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, issue = 1'b0, fmt_mem = 1'b0, ac_norm = 1'b0, slow = 1'b0;
  logic sq_ovf = 1'b0, sq_unf = 1'b0, sq_inx = 1'b0, mem_ready;
  logic [11:0] opcode = 12'h000;
  logic [127:0] src_data = 128'h0;
  logic [31:0] dst_addr = 32'h0;
  logic [3:0] ac_mask = 4'h0;
  logic [63:0] fp_src = 64'h0;
  logic busy, mem_valid, done, fault;
  logic [31:0] mem_addr, mem_data;
  logic [2:0] mem_nbytes;
  logic [1:0] fault_kind;
  logic [3:0] fp_exc;
  int n_mismatch = 0;
  int cmp_count = 0;
  localparam logic [127:0] SRC = 128'h44434241_34333231_24232221_14131211;
  sse_exec dut_u (.I_CORE_CLK(clk), .I_RST(rst), .I_ISSUE(issue), .I_FMT_MEM(fmt_mem),
    .I_OPCODE(opcode), .I_SRC_DATA(src_data), .I_DST_ADDR(dst_addr), .I_AC_NORM(ac_norm),
    .I_AC_MASK(ac_mask), .I_FP_SRC(fp_src), .I_SQ_OVF(sq_ovf), .I_SQ_UNF(sq_unf),
    .I_SQ_INX(sq_inx), .I_MEM_READY(mem_ready), .O_BUSY(busy), .O_MEM_VALID(mem_valid),
    .O_MEM_ADDR(mem_addr), .O_MEM_DATA(mem_data), .O_MEM_NBYTES(mem_nbytes), .O_DONE(done),
    .O_FAULT(fault), .O_FAULT_KIND(fault_kind), .O_FP_EXC(fp_exc));
  sse_mem_model mem_u (.clk(clk), .rst(rst), .slow(slow), .valid(mem_valid),
    .addr(mem_addr), .data(mem_data), .nbytes(mem_nbytes), .ready(mem_ready));
  initial begin
    forever #10 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 200; i++) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) return;
    end
    n_mismatch++;
    give_verdict();
  endtask
  // one edge with the request up, then lowered; outputs looked at 1 ns later
  task automatic launch(input logic mem, input logic [11:0] opc, input logic [127:0] src);
    mem_u.got_addr.delete();
    mem_u.got_data.delete();
    mem_u.got_nb.delete();
    @(posedge clk);
    fmt_mem <= mem;
    opcode <= opc;
    src_data <= src;
    issue <= 1'b1;
    @(posedge clk);
    issue <= 1'b0;
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic do_store(input logic [7:0] opc, input logic [127:0] src, input int nw,
      input logic [2:0] nb);
    logic [31:0] w;
    launch(1'b1, {4'h0, opc}, src);
    `SSE_CHK("mem_valid", 1'b1, mem_valid)
    `SSE_CHK("busy", 1'b1, busy)
    wait_done();
    `SSE_CHK("idle", 1'b0, busy)
    `SSE_CHK("store_fault", 1'b0, fault)
    `SSE_CHK("beats", nw, mem_u.got_addr.size())
    for (int k = 0; k < nw; k++) begin
      w = src[32 * k +: 32];
      w = (nb == 3'h1) ? {24'h0, w[7:0]} : (nb == 3'h2) ? {16'h0, w[15:0]} : w;
      `SSE_CHK("beat_addr", dst_addr + 32'(4 * k), mem_u.got_addr[k])
      `SSE_CHK("beat_data", w, mem_u.got_data[k])
      `SSE_CHK("beat_nbytes", nb, mem_u.got_nb[k])
    end
  endtask
  task automatic do_int_ovf(input logic [7:0] opc, input logic [31:0] v);
    launch(1'b1, {4'h0, opc}, {96'h0, v});
    `SSE_CHK("ovf_done", 1'b1, done)
    `SSE_CHK("ovf_fault", 1'b1, fault)
    `SSE_CHK("ovf_kind", FLT_INT_OVF, fault_kind)
    repeat (3) @(posedge clk);
    `SSE_CHK("ovf_beats", 0, mem_u.got_addr.size())
  endtask
  task automatic do_root(input logic [11:0] opc, input logic [63:0] x, input logic nrm,
      input logic [3:0] msk, input logic [2:0] fl, input logic [3:0] ex, input logic resv);
    logic known;
    logic [1:0] kind;
    known = (opc == OPC_SQRT_REAL) || (opc == OPC_SQRT_LONG);
    kind = resv ? FLT_RESV_ENC : (|(ex & ~msk)) ? FLT_FP_EXC : FLT_NONE;
    @(posedge clk);
    fp_src <= x;
    ac_norm <= nrm;
    ac_mask <= msk;
    {sq_ovf, sq_unf, sq_inx} <= fl;
    launch(1'b0, opc, SRC);
    `SSE_CHK("root_done", known, done)
    `SSE_CHK("root_exc", known ? ex : 4'h0, fp_exc)
    `SSE_CHK("root_fault", known && kind != FLT_NONE, fault)
    `SSE_CHK("root_kind", known ? kind : FLT_NONE, fault_kind)
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1;
    `SSE_CHK("rst_nbytes", BYTES_WORD, mem_nbytes)
    `SSE_CHK("rst_busy", 1'b0, busy)
    // first registers of each group are even or a multiple of four by construction
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      slow <= s[0];
      dst_addr <= 32'h0000_1000 + 32'(s * 32'h40);
      do_store(OPC_SAVE_WORD, SRC, 1, BYTES_WORD);
      do_store(OPC_SAVE_ORD_BYTE, SRC, 1, BYTES_BYTE);
      do_store(OPC_SAVE_ORD_SHORT, SRC, 1, BYTES_SHORT);
      do_store(OPC_SAVE_LONG, SRC, 2, BYTES_WORD);
      do_store(OPC_SAVE_TRIPLE, SRC, 3, BYTES_WORD);
      do_store(OPC_SAVE_QUAD, SRC, 4, BYTES_WORD);
    end
    do_store(OPC_SAVE_INT_BYTE, 128'hFFFF_FF80, 1, BYTES_BYTE);
    do_store(OPC_SAVE_INT_BYTE, 128'h7F, 1, BYTES_BYTE);
    do_store(OPC_SAVE_INT_SHORT, 128'h7FFF, 1, BYTES_SHORT);
    do_store(OPC_SAVE_ORD_BYTE, 128'h1FF, 1, BYTES_BYTE);
    do_int_ovf(OPC_SAVE_INT_BYTE, 32'h0000_0080);
    do_int_ovf(OPC_SAVE_INT_BYTE, 32'hFFFF_FF7F);
    do_int_ovf(OPC_SAVE_INT_SHORT, 32'h0000_8000);
    do_int_ovf(OPC_SAVE_INT_SHORT, 32'hFFFF_7FFF);
    // upper half of a real operand is junk that must be ignored
    do_root(OPC_SQRT_REAL, 64'hFFFFFFFF_3F800000, 1'b1, 4'h0, 3'h0, 4'h0, 1'b0);
    do_root(OPC_SQRT_REAL, 64'h0_BF800000, 1'b0, 4'h0, 3'h0, 4'h4, 1'b0);
    do_root(OPC_SQRT_REAL, 64'h0_BF800000, 1'b0, 4'h4, 3'h0, 4'h4, 1'b0);
    do_root(OPC_SQRT_REAL, 64'h0_80000000, 1'b0, 4'h0, 3'h0, 4'h0, 1'b0);
    do_root(OPC_SQRT_REAL, 64'h0_7F800001, 1'b0, 4'h0, 3'h0, 4'h4, 1'b0);
    do_root(OPC_SQRT_REAL, 64'h0_7FC00000, 1'b0, 4'h0, 3'h0, 4'h0, 1'b0);
    do_root(OPC_SQRT_REAL, 64'h0_00000001, 1'b1, 4'h0, 3'h1, 4'h0, 1'b1);
    do_root(OPC_SQRT_REAL, 64'h0_00000001, 1'b0, 4'h0, 3'h0, 4'h0, 1'b0);
    do_root(OPC_SQRT_REAL, 64'h0_3F800000, 1'b0, 4'h0, 3'h4, 4'h1, 1'b0);
    do_root(OPC_SQRT_REAL, 64'h0_3F800000, 1'b0, 4'h1, 3'h4, 4'h1, 1'b0);
    do_root(OPC_SQRT_REAL, 64'h0_3F800000, 1'b0, 4'h0, 3'h2, 4'h2, 1'b0);
    do_root(OPC_SQRT_REAL, 64'h0_3F800000, 1'b0, 4'h8, 3'h1, 4'h8, 1'b0);
    do_root(OPC_SQRT_LONG, 64'hBFF00000_00000000, 1'b0, 4'h0, 3'h0, 4'h4, 1'b0);
    do_root(OPC_SQRT_LONG, 64'h7FF00000_00000001, 1'b0, 4'h0, 3'h0, 4'h4, 1'b0);
    do_root(OPC_SQRT_LONG, 64'h00000000_BF800000, 1'b0, 4'h0, 3'h0, 4'h0, 1'b0);
    do_root(12'h689, 64'h0_BF800000, 1'b0, 4'h0, 3'h0, 4'h0, 1'b0);
    give_verdict();
  end
endmodule // store_and_sqrt_exec_tb
`default_nettype wire
